// ### rts_core_model.sv
// Behavioural model of the core that the sequencer holds in reset.
`timescale 1ns/1ps

module rts_core_model (
	// Clock and bench commands
	input  wire logic ref_clk,
	input  wire logic sleep_req,
	input  wire logic wdt_req,
	// Sequencer side
	input  wire logic core_reset,
	input  wire logic core_wake,
	output logic      core_sleeping,
	output logic      wdt_expire
);
	// A reset or a wake returns the core to run; sleep is entered only while running.
	always_ff @(posedge ref_clk) begin
		wdt_expire <= wdt_req;
		if (core_reset || core_wake) begin
			core_sleeping <= 1'b0;
		end else if (sleep_req) begin
			core_sleeping <= 1'b1;
		end
	end
endmodule

// ### rts_pkg.sv
// Constants, types and register map of the reset and timeout sequencer.
package rts_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ      = 50_000_000;
	localparam int CLK_PER_US  = CLK_HZ / 1_000_000;
	localparam int POWERUP_TIMER_MS     = 72;
	localparam int POWERUP_TIMER_CYC    = POWERUP_TIMER_MS * (CLK_HZ / 1000);
	localparam int OST_EDGES   = 1024;
	localparam int GLITCH_NS   = 2000;
	localparam int GLITCH_CYC  = (GLITCH_NS * CLK_PER_US + 999) / 1000;
	localparam int BOD_MIN_US  = 100;
	localparam int BOD_MIN_CYC = BOD_MIN_US * CLK_PER_US;

	// ****************************************
	// Register map (printed index, byte address)
	// ****************************************
	localparam logic [11:0] IDX_POWER_CONTROL_FLAGS  = 12'h08e;
	localparam logic [11:0] IDX_STAT  = 12'h08f;
	localparam logic [11:0] IDX_KEEP  = 12'h090;
	localparam logic [11:0] ADDR_POWER_CONTROL_FLAGS = 12'h238;
	localparam logic [11:0] ADDR_STAT = 12'h23c;
	localparam logic [11:0] ADDR_KEEP = 12'h240;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BIT_BOD  = 0;
	localparam int BIT_POR  = 1;
	localparam int BIT_SPEED_CHOICE_FLAG = 3;
	localparam int BIT_TO   = 0;
	localparam int BIT_PD   = 1;
	localparam int BIT_CAUSE = 2;
	localparam logic [7:0] POWER_CONTROL_FLAGS_RST   = 8'h08;
	localparam logic [7:0] POWER_CONTROL_FLAGS_WMASK = 8'h0b;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		OSC_LP    = 3'h0,
		OSC_XT    = 3'h1,
		OSC_HS    = 3'h2,
		OSC_EC    = 3'h3,
		OSC_INTERNAL_RC_OSC = 3'h4,
		OSC_ER    = 3'h5
	} rts_osc_t;

	typedef enum logic [3:0] {
		ST_HOLD = 4'h1,
		ST_POWERUP_TIMER = 4'h2,
		ST_OST  = 4'h4,
		ST_RUN  = 4'h8
	} rts_state_t;

	// One-hot reset cause, as shown in the status register.
	localparam logic [5:0] CAUSE_POR      = 6'h01;
	localparam logic [5:0] CAUSE_PIN_RUN  = 6'h02;
	localparam logic [5:0] CAUSE_PIN_SLP  = 6'h04;
	localparam logic [5:0] CAUSE_WDT_RST  = 6'h08;
	localparam logic [5:0] CAUSE_WDT_WAKE = 6'h10;
	localparam logic [5:0] CAUSE_BOD      = 6'h20;

	typedef struct packed {
		rts_osc_t osc_mode;
		logic     powerup_timer_disable;
		logic     bod_enable;
	} rts_cfg_t;

endpackage

// ### rts_top.sv
// Reset sequencer: cause tracking, power-up and start-up timers, speed select.
//
// Functional notes
// - Software switches RC clock between two speeds.
// - Low speed fixed; high speed follows resistor.
// - Speed flag selects active clock speed.
// - Six distinct reset causes are recognised.
// - Core resets on all causes except wake.
// - Retained register unset on power-on, kept otherwise.
// - Reset pin glitches below minimum width ignored.
// - Power-on detector holds reset, ignores later droop.
// - Power-up timer after power-on or brown-out.
// - Timer-disable bit set skips power-up timer.
// - Start-up timer adds 1024 crystal edges.
// - Start-up timer: crystal modes, power-on or wake.
// - Brown-out enable bit turns detection on.
// - Brown-out longer than minimum duration resets.
// - Wait for supply, then run power-up timer.
// - Brown-out during timer restarts the timer.
// - Power-up timer then start-up; RC disabled: none.
// - Timers ignore pin; release starts immediately.
// - Power control register at index 8Eh.
// - Brown-out flag cleared by brown-out, set by software.
// - Power-on flag zero at power-on, software sets.
// - Timeout and sleep flags follow reset cause.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps

module rts_top
	import rts_pkg::*;
#(
	parameter int POWERUP_TIMER_CYCLES   = POWERUP_TIMER_CYC,
	parameter int BOD_CYCLES    = BOD_MIN_CYC,
	parameter int OST_COUNT     = OST_EDGES,
	parameter int GLITCH_CYCLES = GLITCH_CYC
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Pins and analog detectors
	input  wire logic        por_detect,
	input  wire logic        brownout_low,
	input  wire logic        ext_reset_pin_n,
	input  wire logic        osc1_in,
	// Configuration word, static
	input  wire rts_cfg_t    cfg,
	// Watchdog and core status
	input  wire logic        wdt_expire,
	input  wire logic        core_sleeping,
	// Outputs to core and clock tree
	output logic             core_reset,
	output logic             core_hold,
	output logic             core_wake,
	output logic             osc_low_speed
);

	localparam int PW = $clog2(POWERUP_TIMER_CYCLES + 1);
	localparam int BW = $clog2(BOD_CYCLES + 1);
	localparam int OW = $clog2(OST_COUNT + 1);
	localparam int GW = $clog2(GLITCH_CYCLES + 1);

	// ****************************************
	// Input synchronisers
	// ****************************************

	// All four pin-level inputs are asynchronous to ref_clk.
	logic [3:0] sync_a;
	logic [3:0] sync_b;
	logic       osc_prev;

	// Reset value treats the pin as released and the supply as still low, so the
	// sequencer cannot leave HOLD on stale synchroniser contents right after reset.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync_a   <= 4'h5;
			sync_b   <= 4'h5;
			osc_prev <= 1'b0;
		end else begin
			sync_a   <= {osc1_in, ext_reset_pin_n, brownout_low, por_detect};
			sync_b   <= sync_a;
			osc_prev <= sync_b[3];
		end
	end

	wire por_s    = sync_b[0];
	wire bo_s     = sync_b[1];
	wire pin_n_s  = sync_b[2];
	wire osc_s    = sync_b[3];
	// Edges above half of ref_clk would be missed; crystals stay below that.
	wire osc_rise = osc_s & ~osc_prev;

	// ****************************************
	// Reset pin noise filter
	// ****************************************

	logic [GW-1:0] glitch_cnt;
	logic          pin_low;

	// A low level must persist for the filter time before it counts.
	wire glitch_done = (glitch_cnt == GW'(GLITCH_CYCLES - 1));
	wire next_pin_low = ~pin_n_s & (pin_low | glitch_done);
	wire pin_fall = next_pin_low & ~pin_low;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			glitch_cnt <= '0;
			pin_low    <= 1'b0;
		end else begin
			glitch_cnt <= (pin_n_s | pin_low) ? '0 : glitch_cnt + 1'b1;
			pin_low    <= next_pin_low;
		end
	end

	// ****************************************
	// Brown-out qualification
	// ****************************************

	logic [BW-1:0] bod_cnt;
	logic          bod_trip;

	// Detection is gated by the configuration enable.
	wire bo_act = cfg.bod_enable & bo_s;
	// Only a dip longer than the minimum duration trips the reset.
	wire bod_done = (bod_cnt == BW'(BOD_CYCLES - 1));
	wire next_bod_trip = bo_act & (bod_trip | bod_done);
	// Power-on detector only matters while held in reset.
	wire supply_ok = ~por_s & ~bo_act;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			bod_cnt  <= '0;
			bod_trip <= 1'b0;
		end else begin
			bod_cnt  <= (!bo_act || bod_trip) ? '0 : bod_cnt + 1'b1;
			bod_trip <= next_bod_trip;
		end
	end

	// ****************************************
	// Sequencer state machine
	// ****************************************

	rts_state_t    state;
	rts_state_t    next_state;
	logic [PW-1:0] powerup_timer_cnt;
	logic [OW-1:0] ost_cnt;
	logic          por_pending;
	logic          waking;

	wire st_hold = (state == ST_HOLD);
	wire st_powerup_timer = (state == ST_POWERUP_TIMER);
	wire st_ost  = (state == ST_OST);
	wire st_run  = (state == ST_RUN);

	// Crystal modes are the only ones that need a start-up wait.
	wire crystal = (cfg.osc_mode == OSC_LP) | (cfg.osc_mode == OSC_XT) |
	               (cfg.osc_mode == OSC_HS);
	wire use_ost = crystal & por_pending;

	wire powerup_timer_done = (powerup_timer_cnt == PW'(POWERUP_TIMER_CYCLES - 1));
	wire ost_done  = osc_rise & (ost_cnt == OW'(OST_COUNT - 1));

	// Watchdog events are split by whether the core is asleep.
	wire ev_wdt_wake = st_run & wdt_expire & core_sleeping;
	wire ev_wdt_rst  = st_run & wdt_expire & ~core_sleeping;
	wire ev_bod      = ~st_hold & bod_trip;
	wire ev_pin_slp  = pin_fall & core_sleeping;
	wire ev_pin_run  = pin_fall & ~core_sleeping;
	wire wake_end    = st_ost & waking & ost_done;

	// Timers count from the supply, never from the reset pin.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_HOLD: begin
				if (supply_ok) begin
					if (!cfg.powerup_timer_disable)
						next_state = ST_POWERUP_TIMER;
					else if (use_ost)
						next_state = ST_OST;
					else
						next_state = ST_RUN;
				end
			end
			ST_POWERUP_TIMER: begin
				if (bod_trip)
					next_state = ST_HOLD;
				else if (powerup_timer_done)
					next_state = use_ost ? ST_OST : ST_RUN;
			end
			ST_OST: begin
				if (bod_trip)
					next_state = ST_HOLD;
				else if (ost_done)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (bod_trip)
					next_state = ST_HOLD;
				else if (ev_wdt_wake && crystal)
					next_state = ST_OST;
			end
			default: next_state = ST_HOLD;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			state <= ST_HOLD;
		else
			state <= next_state;
	end

	// Leaving the timer states clears the counts, so a brown-out restarts them.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			powerup_timer_cnt <= '0;
			ost_cnt  <= '0;
		end else begin
			powerup_timer_cnt <= st_powerup_timer ? powerup_timer_cnt + 1'b1 : '0;
			ost_cnt  <= !st_ost ? '0 : ost_cnt + OW'(osc_rise);
		end
	end

	// Power-on start-up wait is owed until the core first runs.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			por_pending <= 1'b1;
			waking      <= 1'b0;
		end else begin
			if (next_state == ST_RUN)
				por_pending <= 1'b0;
			if (ev_wdt_wake && crystal)
				waking <= 1'b1;
			else if (next_state != ST_OST)
				waking <= 1'b0;
		end
	end

	// ****************************************
	// Core reset, hold and wake outputs
	// ****************************************

	// A wake keeps the core frozen, not reset, so its registers survive.
	wire seq_reset = st_hold | st_powerup_timer | (st_ost & ~waking);
	wire next_core_reset = seq_reset | pin_low | ev_wdt_rst | ev_bod;
	wire next_core_hold  = st_ost & waking & ~ost_done;
	wire next_core_wake  = (ev_wdt_wake & ~crystal) | wake_end;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			core_reset <= 1'b1;
			core_hold  <= 1'b0;
			core_wake  <= 1'b0;
		end else begin
			core_reset <= next_core_reset;
			core_hold  <= next_core_hold;
			core_wake  <= next_core_wake;
		end
	end

	// ****************************************
	// APB decode
	// ****************************************

	wire hit_power_control_flags = (paddr == ADDR_POWER_CONTROL_FLAGS);
	wire hit_stat = (paddr == ADDR_STAT);
	wire hit_keep = (paddr == ADDR_KEEP);
	wire hit_any  = hit_power_control_flags | hit_stat | hit_keep;
	wire setup    = psel & ~penable;
	// Writes land only at the completing edge of the access phase.
	wire commit   = psel & penable & pready & pwrite & ~pslverr;
	wire wr_power_control_flags  = commit & hit_power_control_flags;
	wire wr_keep  = commit & hit_keep;

	// ****************************************
	// Power control and status registers
	// ****************************************

	logic [7:0] power_control_flags;
	logic [7:0] keep_reg;
	logic       to_flag;
	logic       pd_flag;
	logic [5:0] cause;

	// Software may only touch the brown-out, power-on and speed bits.
	wire [7:0] power_control_flags_sw = wr_power_control_flags ?
		((power_control_flags & ~POWER_CONTROL_FLAGS_WMASK) | (pwdata[7:0] & POWER_CONTROL_FLAGS_WMASK)) : power_control_flags;
	// Full resets restore the speed bit; a wake leaves it.
	wire full_rst = ev_pin_run | ev_pin_slp | ev_wdt_rst | ev_bod;

	logic [7:0] next_power_control_flags;
	// Hardware events win over a software write in the same cycle.
	always_comb begin
		next_power_control_flags = power_control_flags_sw;
		if (full_rst)
			next_power_control_flags[BIT_SPEED_CHOICE_FLAG] = 1'b1;
		if (ev_bod)
			next_power_control_flags[BIT_BOD] = 1'b0;
	end

	// Power-on clears the power-on bit; nothing else changes it but software.
	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			power_control_flags <= POWER_CONTROL_FLAGS_RST;
		else
			power_control_flags <= next_power_control_flags;
	end

	logic [5:0] next_cause;
	// Record which of the six sources caused the latest reset.
	always_comb begin
		next_cause = cause;
		if (ev_bod)
			next_cause = CAUSE_BOD;
		else if (ev_wdt_wake)
			next_cause = CAUSE_WDT_WAKE;
		else if (ev_wdt_rst)
			next_cause = CAUSE_WDT_RST;
		else if (ev_pin_slp)
			next_cause = CAUSE_PIN_SLP;
		else if (ev_pin_run)
			next_cause = CAUSE_PIN_RUN;
	end

	// Timeout and sleep flags move only on the listed events.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			to_flag <= 1'b1;
			pd_flag <= 1'b1;
			cause   <= CAUSE_POR;
		end else begin
			cause <= next_cause;
			if (ev_wdt_wake) begin
				to_flag <= 1'b0;
				pd_flag <= 1'b0;
			end else if (ev_wdt_rst) begin
				to_flag <= 1'b0;
			end else if (ev_pin_slp) begin
				to_flag <= 1'b1;
				pd_flag <= 1'b0;
			end
		end
	end

	// No reset branch: contents are undefined after power-on and survive all else.
	always_ff @(posedge ref_clk) begin
		if (wr_keep)
			keep_reg <= pwdata[7:0];
	end

	// ****************************************
	// Clock speed select
	// ****************************************

	// Only the RC modes offer the slow setting; low speed is a fixed
	// internal source, while fast follows the external resistor in ER mode.
	wire rc_mode = (cfg.osc_mode == OSC_ER) | (cfg.osc_mode == OSC_INTERNAL_RC_OSC);
	wire next_low_speed = rc_mode & ~power_control_flags[BIT_SPEED_CHOICE_FLAG];

	always_ff @(posedge ref_clk) begin
		if (!rst_n)
			osc_low_speed <= 1'b0;
		else
			osc_low_speed <= next_low_speed;
	end

	// ****************************************
	// APB response
	// ****************************************

	wire [7:0] stat_rd = {cause, pd_flag, to_flag};
	wire [7:0] rd_byte = hit_power_control_flags ? power_control_flags :
	                     hit_stat ? stat_rd :
	                     hit_keep ? keep_reg : 8'h00;

	// Ready follows the setup cycle, giving a single-cycle access phase.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~hit_any;
			if (setup)
				prdata <= {24'h00_0000, rd_byte};
		end
	end

endmodule

// ### rts_top_asserts.sv
// Port-level assertions of the reset sequencer, bound into its top module.
`timescale 1ns/1ps

module rts_top_asserts
	import rts_pkg::*;
#(
	parameter int POWERUP_TIMER_CYCLES   = POWERUP_TIMER_CYC,
	parameter int GLITCH_CYCLES = GLITCH_CYC
) (
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Pins, configuration and core side
	input wire logic        por_detect,
	input wire logic        brownout_low,
	input wire logic        ext_reset_pin_n,
	input wire rts_cfg_t    cfg,
	input wire logic        wdt_expire,
	input wire logic        core_sleeping,
	input wire logic        core_reset,
	input wire logic        core_wake,
	input wire logic        osc_low_speed
);
	int        up_cnt;
	int        low_cnt;
	wire logic mapped = paddr inside {ADDR_POWER_CONTROL_FLAGS, ADDR_STAT, ADDR_KEEP};
	wire logic dual = cfg.osc_mode inside {OSC_ER, OSC_INTERNAL_RC_OSC};

	// Cycles since reset release and with the pin low; both saturate so they never wrap.
	always_ff @(posedge ref_clk) begin
		up_cnt <= !rst_n ? 0 : (up_cnt < 1000000 ? up_cnt + 1 : up_cnt);
		low_cnt <= (ext_reset_pin_n || !rst_n) ? 0 : (low_cnt < 1000 ? low_cnt + 1 : low_cnt);
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_ready_after_setup: assert property (psel && !penable |=> pready && penable)
		else $error("no answer in the access cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr)
		else $error("mapped access refused");
	a_wake_single: assert property (core_wake |=> !core_wake)
		else $error("wake longer than one cycle");
	a_wake_no_reset: assert property (core_wake |-> !core_reset)
		else $error("wake-up reset the core");
	a_powerup_timer_min: assert property ($fell(core_reset) && !cfg.powerup_timer_disable |-> up_cnt >= POWERUP_TIMER_CYCLES + 2)
		else $error("core released before the power-up timer");
	a_pin_forces: assert property (low_cnt == GLITCH_CYCLES + 5 |-> core_reset)
		else $error("long pin pulse did not reset");
	a_release_pin_high: assert property ($fell(core_reset) |-> ext_reset_pin_n && $past(ext_reset_pin_n))
		else $error("core released while pin low");
	a_no_timeout_er: assert property ($rose(rst_n) && cfg.osc_mode == OSC_ER && cfg.powerup_timer_disable && !por_detect
		&& ext_reset_pin_n && !brownout_low |-> ##[1:12] !core_reset)
		else $error("timeout seen with no timer enabled");
	a_speed_write: assert property (psel && penable && pready && pwrite && paddr == ADDR_POWER_CONTROL_FLAGS && dual
		|-> ##2 osc_low_speed == !$past(pwdata[BIT_SPEED_CHOICE_FLAG], 2))
		else $error("speed select does not follow the flag");
	a_wdt_resets: assert property (wdt_expire && !core_sleeping && !core_reset |-> ##[1:3] core_reset)
		else $error("watchdog did not reset the core");
endmodule

bind rts_top rts_top_asserts #(.POWERUP_TIMER_CYCLES(POWERUP_TIMER_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .por_detect(por_detect), .brownout_low(brownout_low),
	.ext_reset_pin_n(ext_reset_pin_n), .cfg(cfg), .wdt_expire(wdt_expire), .core_sleeping(core_sleeping),
	.core_reset(core_reset), .core_wake(core_wake), .osc_low_speed(osc_low_speed));

// ### test_rts_top.sv
// Self-checking bench of the reset sequencer.
`timescale 1ns/1ps

module test_rts_top
	import rts_pkg::*;
;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, por_detect, brownout_low;
	logic        ext_reset_pin_n, osc1_in, osc_run, sleep_req, wdt_req, wdt_expire, core_sleeping;
	logic        core_reset, core_hold, core_wake, osc_low_speed;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, keep;
	rts_cfg_t    cfg;
	logic [32:0] exp_q[$];
	int          errors, checks_done, n;

	rts_top #(.POWERUP_TIMER_CYCLES(50), .BOD_CYCLES(8), .OST_COUNT(16), .GLITCH_CYCLES(10)) i_dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .por_detect(por_detect),
		.brownout_low(brownout_low), .ext_reset_pin_n(ext_reset_pin_n), .osc1_in(osc1_in), .cfg(cfg),
		.wdt_expire(wdt_expire), .core_sleeping(core_sleeping), .core_reset(core_reset),
		.core_hold(core_hold), .core_wake(core_wake), .osc_low_speed(osc_low_speed));
	rts_core_model i_core (.ref_clk(ref_clk), .sleep_req(sleep_req), .wdt_req(wdt_req), .core_reset(core_reset),
		.core_wake(core_wake), .core_sleeping(core_sleeping), .wdt_expire(wdt_expire));

	// The 50 MHz clock, and a crystal that oscillates only while enabled.
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	always #30 if (osc_run) osc1_in = ~osc1_in;

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One transfer; the expectation is noted at setup and matched by the monitor.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_rst(input logic v, input int lim);
		n = 0;
		while (core_reset !== v && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		chk("core_reset", 33'(v), 33'(core_reset));
	endtask

	task automatic wdt_pulse();
		wdt_req <= 1'b1;
		cyc(1);
		wdt_req <= 1'b0;
	endtask

	// Supply comes up after the reset input is released; the detector drops a little later.
	task automatic power_on(input rts_cfg_t c, input logic por);
		rst_n <= 1'b0;
		por_detect <= por;
		cfg <= c;
		cyc(10);
		rst_n <= 1'b1;
		cyc(5);
		por_detect <= 1'b0;
	endtask

	task automatic summarize();
		if (exp_q.size() != 0) errors++;
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Each completed transfer is compared with the oldest noted expectation.
	always @(posedge ref_clk) begin
		if (pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				errors++;
				$display("mismatch apb expected none seen %h", prdata);
			end else begin
				chk("apb", exp_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
			end
		end
	end

	// A hang is cut short well beyond the several hundred cycles the run needs.
	initial begin
		cyc(20000);
		errors++;
		summarize();
	end

	initial begin
		{rst_n, psel, penable, pwrite, brownout_low, osc1_in, osc_run, sleep_req, wdt_req} = '0;
		ext_reset_pin_n = 1'b1;
		por_detect = 1'b1;
		paddr = '0;
		pwdata = '0;
		cfg = '{OSC_ER, 1'b0, 1'b1};
		errors = 0;
		checks_done = 0;
		void'($urandom(6759));
		keep = $urandom & 32'hff;
		// Timer kept on while brown-out detection is on.
		power_on('{OSC_ER, 1'b0, 1'b1}, 1'b1);
		cyc(40);
		chk("core_reset", 33'h1, 33'(core_reset));
		wait_rst(1'b0, 100);
		apb(1'b0, ADDR_POWER_CONTROL_FLAGS, 32'h0, 33'h08);
		apb(1'b0, ADDR_STAT, 32'h0, 33'h07);
		apb(1'b0, 12'h244, 32'h0, 33'h100000000);
		apb(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h03, 33'h0);
		apb(1'b0, ADDR_POWER_CONTROL_FLAGS, 32'h0, 33'h03);
		chk("osc_low_speed", 33'h1, 33'(osc_low_speed));
		apb(1'b1, ADDR_KEEP, keep, 33'h0);
		apb(1'b1, ADDR_STAT, 32'hff, 33'h0);
		apb(1'b1, ADDR_POWER_CONTROL_FLAGS, 32'h0b, 33'h0);
		cyc(3);
		chk("osc_low_speed", 33'h0, 33'(osc_low_speed));
		// A short pin pulse is filtered; a long one resets until the pin is released.
		ext_reset_pin_n <= 1'b0;
		cyc($urandom_range(8, 1));
		ext_reset_pin_n <= 1'b1;
		cyc(10);
		chk("core_reset", 33'h0, 33'(core_reset));
		ext_reset_pin_n <= 1'b0;
		cyc(30);
		chk("core_reset", 33'h1, 33'(core_reset));
		ext_reset_pin_n <= 1'b1;
		wait_rst(1'b0, 6);
		apb(1'b0, ADDR_STAT, 32'h0, 33'h0b);
		apb(1'b0, ADDR_KEEP, 32'h0, {1'b0, keep});
		// Watchdog reset while running, then watchdog wake from sleep.
		wdt_pulse();
		wait_rst(1'b1, 6);
		wait_rst(1'b0, 100);
		apb(1'b0, ADDR_STAT, 32'h0, 33'h22);
		apb(1'b0, ADDR_POWER_CONTROL_FLAGS, 32'h0, 33'h0b);
		sleep_req <= 1'b1;
		cyc(1);
		sleep_req <= 1'b0;
		cyc(3);
		wdt_pulse();
		n = 0;
		while (core_wake !== 1'b1 && n < 10) begin
			cyc(1);
			n++;
		end
		chk("core_wake", 33'h1, 33'(core_wake));
		chk("core_reset", 33'h0, 33'(core_reset));
		apb(1'b0, ADDR_STAT, 32'h0, 33'h40);
		apb(1'b0, ADDR_KEEP, 32'h0, {1'b0, keep});
		// A long supply dip resets; a second dip during the power-up timer restarts it.
		brownout_low <= 1'b1;
		cyc(20);
		brownout_low <= 1'b0;
		chk("core_reset", 33'h1, 33'(core_reset));
		cyc(30);
		brownout_low <= 1'b1;
		cyc(20);
		brownout_low <= 1'b0;
		cyc(45);
		chk("core_reset", 33'h1, 33'(core_reset));
		wait_rst(1'b0, 100);
		apb(1'b0, ADDR_POWER_CONTROL_FLAGS, 32'h0, 33'h0a);
		// Crystal power-on: the start-up timer waits for oscillator edges.
		power_on('{OSC_XT, 1'b0, 1'b1}, 1'b1);
		cyc(80);
		chk("core_reset", 33'h1, 33'(core_reset));
		osc_run <= 1'b1;
		wait_rst(1'b0, 200);
		osc_run <= 1'b0;
		apb(1'b0, ADDR_POWER_CONTROL_FLAGS, 32'h0, 33'h08);
		// Watchdog wake in crystal mode: the core is held, not reset, until start-up ends.
		sleep_req <= 1'b1;
		cyc(1);
		sleep_req <= 1'b0;
		cyc(3);
		wdt_pulse();
		cyc(3);
		chk("core_hold", 33'h1, 33'(core_hold));
		chk("core_reset", 33'h0, 33'(core_reset));
		osc_run <= 1'b1;
		n = 0;
		while (core_wake !== 1'b1 && n < 200) begin
			cyc(1);
			n++;
		end
		osc_run <= 1'b0;
		chk("core_wake", 33'h1, 33'(core_wake));
		chk("core_hold", 33'h0, 33'(core_hold));
		apb(1'b0, ADDR_STAT, 32'h0, 33'h40);
		// Resistor mode with the timer disabled has no timeout at all.
		power_on('{OSC_ER, 1'b1, 1'b0}, 1'b0);
		wait_rst(1'b0, 3);
		summarize();
	end
endmodule
